// File: src/intc_pkg.sv
// Purpose: shared constants and types of the prioritised vector interrupt unit
// Assumes: 8-bit register port, one clock, synchronous active-low reset
// Notes: slot order below is the fixed tie-break order inside one level
package intc_pkg;

  localparam logic [7:0] ADDR_PIN_SRC = 8'ha6;
  localparam logic [7:0] ADDR_IEN_PRI = 8'ha8;
  localparam logic [7:0] ADDR_PRIO_LO = 8'ha9;
  localparam logic [7:0] ADDR_IEN_SEC = 8'hb8;
  localparam logic [7:0] ADDR_PRIO_HI = 8'hb9;
  localparam logic [7:0] ADDR_FLAGS = 8'hc0;

  localparam logic [7:0] RST_PIN_SRC = 8'h01;
  localparam logic [7:0] RST_IEN_PRI = 8'h00;
  localparam logic [7:0] RST_IEN_SEC = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;

  // writable bits; the rest read as zero
  localparam logic [7:0] MASK_IEN_PRI = 8'hbf;
  localparam logic [7:0] MASK_IEN_SEC = 8'hbf;
  localparam logic [7:0] MASK_PIN_SRC = 8'h3b;
  localparam logic [7:0] MASK_PRIO = 8'h3f;

  localparam int IEN_GLOBAL = 7;
  localparam int IEN_T2 = 5;
  localparam int IEN_SER = 4;
  localparam int IEN_T1 = 3;
  localparam int IEN_POF = 2;
  localparam int IEN_T0 = 1;
  localparam int IEN_PIN = 0;

  localparam int IEN_T2RLD = 7;
  localparam int IEN_WU = 5;
  localparam int IEN_USB = 4;
  localparam int IEN_USB_WAKEUP_REQUEST = 3;
  localparam int IEN_SPI = 2;
  localparam int IEN_RF = 1;
  localparam int IEN_RF_LINK_READY = 0;

  localparam int PSEL_PIN0 = 3;
  localparam int PSEL_PIN1 = 4;
  localparam int PSEL_PIN2 = 5;
  localparam int PSEL_MSPI = 1;
  localparam int PSEL_SSPI = 0;

  localparam int FLG_T2RLD = 7;
  localparam int FLG_T2 = 6;
  localparam int FLG_WU = 5;
  localparam int FLG_USB = 4;
  localparam int FLG_USB_WAKEUP_REQUEST = 3;
  localparam int FLG_SPI = 2;
  localparam int FLG_RF = 1;
  localparam int FLG_RF_LINK_READY = 0;

  localparam int NUM_GROUPS = 6;
  localparam int NUM_SLOTS = 12;
  localparam int NUM_LEVELS = 4;

  // slot = 2*group + side
  localparam logic [3:0] SLOT_PIN = 4'h0;
  localparam logic [3:0] SLOT_RF_LINK_READY = 4'h1;
  localparam logic [3:0] SLOT_T0 = 4'h2;
  localparam logic [3:0] SLOT_RF = 4'h3;
  localparam logic [3:0] SLOT_POF = 4'h4;
  localparam logic [3:0] SLOT_SPI = 4'h5;
  localparam logic [3:0] SLOT_T1 = 4'h6;
  localparam logic [3:0] SLOT_USB_WAKEUP_REQUEST = 4'h7;
  localparam logic [3:0] SLOT_SER = 4'h8;
  localparam logic [3:0] SLOT_USB = 4'h9;
  localparam logic [3:0] SLOT_T2 = 4'ha;
  localparam logic [3:0] SLOT_WU = 4'hb;

  localparam logic [15:0] VECTOR_TABLE [0:11] = '{
    16'h0003, 16'h0043, 16'h000b, 16'h004b, 16'h0013, 16'h0053,
    16'h001b, 16'h005b, 16'h0023, 16'h0063, 16'h002b, 16'h006b
  };

  typedef struct packed {
    logic pin_input_two;
    logic pin_input_one;
    logic pin_input_zero;
    logic timer_zero_overflow;
    logic power_fail_request_n;
    logic timer_one_overflow;
    logic serial_receive_request;
    logic serial_transmit_request;
    logic timer_two_event;
    logic timer_two_reload_event;
    logic rf_link_ready;
    logic rf_transceiver_request_n;
    logic master_spi_done;
    logic slave_spi_done;
    logic oscillator_started;
    logic usb_wakeup_request;
    logic usb_request_n;
    logic internal_wakeup_request;
  } sources_s;

  // wakeup enables taken from the wakeup control register
  typedef struct packed {
    logic rf;
    logic osc;
    logic tick;
  } wake_s;

  typedef enum logic [1:0] {OFFER_IDLE, OFFER_UP, OFFER_SETTLE} offer_e;

endpackage

// File: src/edge_detect.sv
// Purpose: registered history of request lines with rise and fall strobes
// Assumes: inputs synchronous to clk
// Notes: RST_VAL should match the idle level so reset gives no false edge
`timescale 1ns/1ps
module edge_detect #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] prev_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_ff <= RST_VAL;
    end else begin
      prev_ff <= din;
    end
  end

  assign rise = din & ~prev_ff;
  assign fall = ~din & prev_ff;
endmodule

// File: src/priority_pick.sv
// Purpose: picks the winning slot among pending requests by level and order
// Assumes: slot = 2*group + side, group levels from two priority registers
// Notes: purely combinational; result is registered by the caller
`timescale 1ns/1ps
module priority_pick (
  input wire logic [intc_pkg::NUM_SLOTS-1:0] req,
  input wire logic [intc_pkg::NUM_GROUPS-1:0] prio_lo,
  input wire logic [intc_pkg::NUM_GROUPS-1:0] prio_hi,
  output logic found,
  output logic [3:0] slot,
  output logic [1:0] level
);
  import intc_pkg::*;

  function automatic logic [1:0] slot_level(input int s, input logic [5:0] lo,
                                            input logic [5:0] hi);
    slot_level = {hi[s/2], lo[s/2]};
  endfunction

  always_comb begin
    found = 1'b0;
    slot = 4'h0;
    level = 2'h0;
    // top level first; within it the lowest slot wins
    for (int l = NUM_LEVELS - 1; l >= 0; l--) begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        if (!found && req[s] && (slot_level(s, prio_lo, prio_hi) == l[1:0])) begin
          found = 1'b1;
          slot = s[3:0];
          level = l[1:0];
        end
      end
    end
  end
endmodule

// File: src/prioritised_vector_interrupt_unit.sv
// Purpose: eighteen-source interrupt controller with four levels and vectors
// Assumes: cpu acks an offer with one pulse, signals return with another
// Notes: read data appear one cycle after the read strobe, zero otherwise
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module prioritised_vector_interrupt_unit (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire intc_pkg::sources_s src,
  input wire intc_pkg::wake_s wake_en,
  input wire logic pin_edge_mode,
  input wire logic pof_edge_mode,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [1:0] irq_level,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic [3:0] in_service
);
  import intc_pkg::*;

  function automatic logic [1:0] top_level(input logic [3:0] isr);
    if (isr[3]) begin
      top_level = 2'h3;
    end else if (isr[2]) begin
      top_level = 2'h2;
    end else if (isr[1]) begin
      top_level = 2'h1;
    end else begin
      top_level = 2'h0;
    end
  endfunction

  function automatic logic [3:0] level_bit(input logic [1:0] lvl);
    level_bit = 4'h1 << lvl;
  endfunction

  // registers
  logic [7:0] pin_src_ff;
  logic [7:0] ien_pri_ff;
  logic [7:0] ien_sec_ff;
  logic [7:0] prio_lo_ff;
  logic [7:0] prio_hi_ff;
  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;
  logic [7:0] rdata_ff;
  logic pin_pend_ff;
  logic nxt_pin_pend;
  logic pof_pend_ff;
  logic nxt_pof_pend;
  logic [3:0] isr_ff;
  logic [3:0] nxt_isr;
  offer_e offer_ff;
  offer_e nxt_offer;
  logic [3:0] slot_ff;
  logic [15:0] vec_ff;
  logic [1:0] lvl_ff;

  // register port decode
  wire wr_pin_src = reg_wr && (reg_addr == ADDR_PIN_SRC);
  wire wr_ien_pri = reg_wr && (reg_addr == ADDR_IEN_PRI);
  wire wr_ien_sec = reg_wr && (reg_addr == ADDR_IEN_SEC);
  wire wr_prio_lo = reg_wr && (reg_addr == ADDR_PRIO_LO);
  wire wr_prio_hi = reg_wr && (reg_addr == ADDR_PRIO_HI);
  wire wr_flags = reg_wr && (reg_addr == ADDR_FLAGS);

  logic [7:0] rd_mux;
  assign rd_mux = (reg_addr == ADDR_PIN_SRC) ? pin_src_ff :
                  (reg_addr == ADDR_IEN_PRI) ? ien_pri_ff :
                  (reg_addr == ADDR_IEN_SEC) ? ien_sec_ff :
                  (reg_addr == ADDR_PRIO_LO) ? prio_lo_ff :
                  (reg_addr == ADDR_PRIO_HI) ? prio_hi_ff :
                  (reg_addr == ADDR_FLAGS) ? flags_ff : 8'h00;

  // edge detection of the edge-sensitive lines
  // order: pin line, pof_n, rf ready, mspi, sspi, osc, usb wakeup, tick
  logic pin_line;
  logic [7:0] edge_in;
  logic [7:0] edge_rise;
  logic [7:0] edge_fall;

  // only one select bit is expected; with more, any low selected pin pulls the line
  assign pin_line = (src.pin_input_zero | ~pin_src_ff[PSEL_PIN0]) &
                    (src.pin_input_one | ~pin_src_ff[PSEL_PIN1]) &
                    (src.pin_input_two | ~pin_src_ff[PSEL_PIN2]);
  assign edge_in = {pin_line, src.power_fail_request_n, src.rf_link_ready,
                    src.master_spi_done, src.slave_spi_done, src.oscillator_started,
                    src.usb_wakeup_request, src.internal_wakeup_request};

  edge_detect #(
    .W(8),
    .RST_VAL(8'hc0)
  ) u_edges (
    .clk(clk),
    .nrst(nrst),
    .din(edge_in),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  wire pin_fall = edge_fall[7];
  wire pof_fall = edge_fall[6];
  wire rf_link_ready_rise = edge_rise[5];
  wire mspi_edge = edge_rise[4] | edge_fall[4];
  wire sspi_edge = edge_rise[3] | edge_fall[3];
  wire osc_edge = edge_rise[2] | edge_fall[2];
  wire usb_wakeup_request_rise = edge_rise[1];
  wire tick_rise = edge_rise[0];

  // vectoring moment: cpu takes the registered offer
  wire take = irq_ack && (offer_ff == OFFER_UP);
  wire take_pin = take && (slot_ff == SLOT_PIN);
  wire take_pof = take && (slot_ff == SLOT_POF);
  wire take_t2 = take && (slot_ff == SLOT_T2);
  wire take_wu = take && (slot_ff == SLOT_WU);
  wire take_usb_wakeup_request = take && (slot_ff == SLOT_USB_WAKEUP_REQUEST);
  wire take_spi = take && (slot_ff == SLOT_SPI);

  // pin and power-fail: level mode follows the line, edge mode latches
  wire pin_active = pin_edge_mode ? pin_pend_ff : ~pin_line;
  wire pof_active = pof_edge_mode ? pof_pend_ff : ~src.power_fail_request_n;

  assign nxt_pin_pend = pin_edge_mode && ((pin_pend_ff && !take_pin) || pin_fall);
  assign nxt_pof_pend = pof_edge_mode && ((pof_pend_ff && !take_pof) || pof_fall);

  // flag sources; events win over any clear in the same cycle
  logic [7:0] flag_set;
  logic [7:0] flag_base;
  logic [7:0] flag_auto_clr;
  assign flag_set[FLG_T2RLD] = src.timer_two_reload_event;
  assign flag_set[FLG_T2] = src.timer_two_event;
  assign flag_set[FLG_WU] = tick_rise && wake_en.tick;
  assign flag_set[FLG_USB] = ~src.usb_request_n;
  assign flag_set[FLG_USB_WAKEUP_REQUEST] = usb_wakeup_request_rise;
  assign flag_set[FLG_SPI] = (mspi_edge && pin_src_ff[PSEL_MSPI]) ||
                             (sspi_edge && pin_src_ff[PSEL_SSPI]) ||
                             (osc_edge && wake_en.osc);
  assign flag_set[FLG_RF] = ~src.rf_transceiver_request_n && wake_en.rf;
  assign flag_set[FLG_RF_LINK_READY] = rf_link_ready_rise;

  // tf2 cleared only if it caused the vector; a lone reload keeps its flag
  assign flag_auto_clr = {1'b0, take_t2 && flags_ff[FLG_T2], take_wu, 1'b0,
                          take_usb_wakeup_request, take_spi, 2'b00};

  assign flag_base = wr_flags ? reg_wdata : flags_ff;

  always_comb begin
    nxt_flags = (flag_base & ~flag_auto_clr) | flag_set;
    // level flags mirror the source: clear when it deasserts
    nxt_flags[FLG_USB] = flag_set[FLG_USB];
    nxt_flags[FLG_RF] = flag_set[FLG_RF];
  end

  // per-slot requests
  logic [NUM_SLOTS-1:0] slot_req;
  logic [NUM_SLOTS-1:0] gated_req;
  assign slot_req[SLOT_PIN] = ien_pri_ff[IEN_PIN] && pin_active;
  assign slot_req[SLOT_RF_LINK_READY] = ien_sec_ff[IEN_RF_LINK_READY] && flags_ff[FLG_RF_LINK_READY];
  assign slot_req[SLOT_T0] = ien_pri_ff[IEN_T0] && src.timer_zero_overflow;
  assign slot_req[SLOT_RF] = ien_sec_ff[IEN_RF] && flags_ff[FLG_RF];
  assign slot_req[SLOT_POF] = ien_pri_ff[IEN_POF] && pof_active;
  assign slot_req[SLOT_SPI] = ien_sec_ff[IEN_SPI] && flags_ff[FLG_SPI];
  assign slot_req[SLOT_T1] = ien_pri_ff[IEN_T1] && src.timer_one_overflow;
  assign slot_req[SLOT_USB_WAKEUP_REQUEST] = ien_sec_ff[IEN_USB_WAKEUP_REQUEST] && flags_ff[FLG_USB_WAKEUP_REQUEST];
  assign slot_req[SLOT_SER] = ien_pri_ff[IEN_SER] &&
                              (src.serial_receive_request || src.serial_transmit_request);
  assign slot_req[SLOT_USB] = ien_sec_ff[IEN_USB] && flags_ff[FLG_USB];
  assign slot_req[SLOT_T2] = ien_pri_ff[IEN_T2] && (flags_ff[FLG_T2] ||
                             (flags_ff[FLG_T2RLD] && ien_sec_ff[IEN_T2RLD]));
  assign slot_req[SLOT_WU] = ien_sec_ff[IEN_WU] && flags_ff[FLG_WU];

  assign gated_req = ien_pri_ff[IEN_GLOBAL] ? slot_req : '0;

  logic best_found;
  logic [3:0] best_slot;
  logic [1:0] best_level;

  priority_pick u_pick (
    .req(gated_req),
    .prio_lo(prio_lo_ff[NUM_GROUPS-1:0]),
    .prio_hi(prio_hi_ff[NUM_GROUPS-1:0]),
    .found(best_found),
    .slot(best_slot),
    .level(best_level)
  );

  // an offer needs a level strictly above the routine now running
  wire may_preempt = (isr_ff == 4'h0) || (best_level > top_level(isr_ff));
  wire want = best_found && may_preempt;
  // a new winner withdraws the offer for a cycle rather than swap it under the cpu
  wire keep_offer = want && (best_slot == slot_ff) && (best_level == lvl_ff);

  // in-service levels: set on vectoring, highest cleared on return
  always_comb begin
    nxt_isr = isr_ff;
    if (irq_return) begin
      nxt_isr = nxt_isr & ~level_bit(top_level(isr_ff));
    end
    if (take) begin
      nxt_isr = nxt_isr | level_bit(lvl_ff);
    end
  end

  // offer sequencing; settle lets taken flags clear before the next pick
  always_comb begin
    case (offer_ff)
      OFFER_IDLE: nxt_offer = want ? OFFER_UP : OFFER_IDLE;
      OFFER_UP: nxt_offer = take ? OFFER_SETTLE : (keep_offer ? OFFER_UP : OFFER_IDLE);
      OFFER_SETTLE: nxt_offer = OFFER_IDLE;
      default: nxt_offer = OFFER_IDLE;
    endcase
  end

  // offered vector is frozen while up so the ack always names what was shown
  wire load_offer = (offer_ff == OFFER_IDLE);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_src_ff <= RST_PIN_SRC;
      ien_pri_ff <= RST_IEN_PRI;
      ien_sec_ff <= RST_IEN_SEC;
      prio_lo_ff <= RST_PRIO;
      prio_hi_ff <= RST_PRIO;
    end else begin
      if (wr_pin_src) begin
        pin_src_ff <= reg_wdata & MASK_PIN_SRC;
      end
      if (wr_ien_pri) begin
        ien_pri_ff <= reg_wdata & MASK_IEN_PRI;
      end
      if (wr_ien_sec) begin
        ien_sec_ff <= reg_wdata & MASK_IEN_SEC;
      end
      if (wr_prio_lo) begin
        prio_lo_ff <= reg_wdata & MASK_PRIO;
      end
      if (wr_prio_hi) begin
        prio_hi_ff <= reg_wdata & MASK_PRIO;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      flags_ff <= RST_FLAGS;
      pin_pend_ff <= 1'b0;
      pof_pend_ff <= 1'b0;
      isr_ff <= 4'h0;
      rdata_ff <= 8'h00;
    end else begin
      flags_ff <= nxt_flags;
      pin_pend_ff <= nxt_pin_pend;
      pof_pend_ff <= nxt_pof_pend;
      isr_ff <= nxt_isr;
      rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      offer_ff <= OFFER_IDLE;
      slot_ff <= 4'h0;
      vec_ff <= 16'h0000;
      lvl_ff <= 2'h0;
    end else begin
      offer_ff <= nxt_offer;
      if (load_offer) begin
        slot_ff <= best_slot;
        vec_ff <= VECTOR_TABLE[best_slot];
        lvl_ff <= best_level;
      end
    end
  end

  assign irq_req = (offer_ff == OFFER_UP);
  assign irq_vector = vec_ff;
  assign irq_level = lvl_ff;
  assign in_service = isr_ff;
  assign reg_rdata = rdata_ff;

endmodule

// File: test/prioritised_vector_interrupt_unit_chk.sv
// Purpose: port-level checks of the prioritised vector interrupt unit
// Assumes: one clock, synchronous active-low reset
// Notes: global enable is shadowed from register writes, it is not a port
`timescale 1ns/1ps
module intc_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [1:0] irq_level,
  input wire logic irq_ack,
  input wire logic irq_return,
  input wire logic [3:0] in_service
);
  import intc_pkg::*;
  logic gen_ff;
  logic nxt_gen;
  logic [3:0] top_bit;
  logic [1:0] top_lvl;
  logic [3:0] clr_top;
  assign nxt_gen = (reg_wr && reg_addr == ADDR_IEN_PRI) ? reg_wdata[IEN_GLOBAL] : gen_ff;
  assign top_bit = in_service[3] ? 4'h8 : in_service[2] ? 4'h4 :
                   in_service[1] ? 4'h2 : {3'h0, in_service[0]};
  assign top_lvl = in_service[3] ? 2'h3 : in_service[2] ? 2'h2 : in_service[1] ? 2'h1 : 2'h0;
  assign clr_top = in_service & ~top_bit;
  always_ff @(posedge clk) begin
    if (!nrst)
      gen_ff <= 1'b0;
    else
      gen_ff <= nxt_gen;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_take; irq_req && irq_ack; endsequence
  sequence s_prio_wr; reg_wr && reg_addr == ADDR_PRIO_LO; endsequence
  sequence s_prio_rd; reg_rd && reg_addr == ADDR_PRIO_LO; endsequence
  property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  property p_prio_rdback;
    s_prio_wr ##1 s_prio_rd |=> reg_rdata == ($past(reg_wdata, 2) & MASK_PRIO);
  endproperty
  property p_ack_drop; s_take |=> !irq_req [*2]; endproperty
  property p_vec_stable;
    irq_req ##1 irq_req |-> $stable(irq_vector) && $stable(irq_level);
  endproperty
  property p_global; !gen_ff ##1 !gen_ff |-> !irq_req; endproperty
  property p_level_gt; irq_req && (|in_service) |-> irq_level > top_lvl; endproperty
  property p_svc_set; s_take |=> in_service[$past(irq_level)]; endproperty
  property p_ret_clear; irq_return && !irq_ack |=> in_service == $past(clr_top); endproperty
  property p_vec_table;
    irq_req |-> irq_vector inside {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
      16'h002b, 16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b};
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  a_prio_rdback: assert property (p_prio_rdback) else $error("priority readback");
  a_ack_drop: assert property (p_ack_drop) else $error("offer after take");
  a_vec_stable: assert property (p_vec_stable) else $error("offer changed");
  a_global: assert property (p_global) else $error("offer while disabled");
  a_level_gt: assert property (p_level_gt) else $error("offer not above service");
  a_svc_set: assert property (p_svc_set) else $error("service bit missing");
  a_ret_clear: assert property (p_ret_clear) else $error("return clear wrong");
  a_vec_table: assert property (p_vec_table) else $error("unknown vector");
endmodule
bind prioritised_vector_interrupt_unit intc_chk chk (.clk, .nrst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .irq_req, .irq_vector, .irq_level, .irq_ack, .irq_return,
  .in_service);

// File: test/cpu_core_model.sv
// Purpose: cpu side partner that takes vector offers and leaves routines
// Assumes: one clock, ack counts only while an offer stands
// Notes: ack latency is set per transfer so prompt and slow takes both occur
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [1:0] delay,
  input wire logic leave,
  output logic irq_ack,
  output logic irq_return,
  output logic [15:0] taken_vec,
  output logic [7:0] taken_cnt
);
  logic ack_ff;
  logic ret_ff;
  logic [1:0] wait_ff;
  logic [15:0] vec_ff;
  logic [7:0] cnt_ff;
  assign irq_ack = ack_ff;
  assign irq_return = ret_ff;
  assign taken_vec = vec_ff;
  assign taken_cnt = cnt_ff;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
      ret_ff <= 1'b0;
      wait_ff <= 2'h0;
      vec_ff <= 16'h0000;
      cnt_ff <= 8'h00;
    end else begin
      ret_ff <= leave;
      ack_ff <= irq_req && !ack_ff && (wait_ff >= delay);
      wait_ff <= (irq_req && !ack_ff && wait_ff < delay) ? wait_ff + 2'h1 : 2'h0;
      if (ack_ff && irq_req) begin
        vec_ff <= irq_vector;
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
endmodule

// File: test/prioritised_vector_interrupt_unit_tb.sv
// Purpose: self-checking bench of the prioritised vector interrupt unit
// Assumes: cpu partner model acks offers, bench plays software and sources
// Notes: one source at a time per vector case, priority cases use timers 0/1
`timescale 1ns/1ps
module prioritised_vector_interrupt_unit_tb;
  import intc_pkg::*;
  localparam logic [17:0] IDLE = 18'h3a042;
  // {addr, reset, readable mask}; 0x55 is unmapped
  localparam logic [23:0] REGS [0:6] = '{24'ha6_01_3b, 24'ha8_00_bf, 24'ha9_00_3f,
    24'hb8_00_bf, 24'hb9_00_3f, 24'hc0_00_ed, 24'h55_00_00};
  // {source bit, primary, secondary, pin select, flags after take, vector}
  localparam logic [55:0] CASES [0:17] = '{
    56'h0f_81_00_08_00_0003, 56'h10_81_00_10_00_0003, 56'h11_81_00_20_00_0003,
    56'h0e_82_00_01_00_000b, 56'h0d_84_00_01_00_0013, 56'h0c_88_00_01_00_001b,
    56'h0b_90_00_01_00_0023, 56'h0a_90_00_01_00_0023, 56'h09_a0_00_01_40_002b,
    56'h08_a0_80_01_80_002b, 56'h07_80_01_01_01_0043, 56'h06_80_02_01_02_004b,
    56'h05_80_04_02_00_0053, 56'h04_80_04_01_00_0053, 56'h03_80_04_00_00_0053,
    56'h02_80_08_01_00_005b, 56'h01_80_10_01_10_0063, 56'h00_80_20_01_00_006b};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pin_edge_mode = 1'b0;
  logic pof_edge_mode = 1'b0;
  logic leave = 1'b0;
  logic [1:0] delay = 2'h0;
  sources_s src = sources_s'(IDLE);
  wake_s wake_en = wake_s'(3'h7);
  logic [7:0] reg_rdata;
  logic irq_req;
  logic irq_ack;
  logic irq_return;
  logic [15:0] irq_vector;
  logic [15:0] taken_vec;
  logic [1:0] irq_level;
  logic [3:0] in_service;
  logic [7:0] taken_cnt;
  int err_count = 0;
  int cmp_count = 0;
  int seed = 62;
  always #25 clk = ~clk;
  prioritised_vector_interrupt_unit dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .src, .wake_en, .pin_edge_mode, .pof_edge_mode, .irq_req,
    .irq_vector, .irq_level, .irq_ack, .irq_return, .in_service);
  cpu_core_model cpu (.clk, .nrst, .irq_req, .irq_vector, .delay, .leave, .irq_ack,
    .irq_return, .taken_vec, .taken_cnt);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // optional write, then a read of the same address with no gap
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    if (w) begin
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    q = reg_rdata;
  endtask
  task automatic wait_take(input logic [7:0] n0);
    for (int i = 0; i < 40 && taken_cnt == n0; i++)
      @(posedge clk);
    if (taken_cnt == n0) begin
      check({8'h00, taken_cnt}, {8'h00, n0 + 8'h01});
      close_out;
    end
    @(negedge clk);
  endtask
  task automatic ret;
    @(posedge clk);
    leave <= 1'b1;
    @(posedge clk);
    leave <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [15:0] win(input logic [7:0] lo, input logic [7:0] hi);
    return ({hi[3], lo[3]} > {hi[1], lo[1]}) ? 16'h001b : 16'h000b;
  endfunction
  initial begin
    logic [55:0] c;
    logic [7:0] q;
    logic [7:0] d;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] n;
    int a;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      xfer(1'b0, REGS[k][23:16], 8'h00, q);
      check({8'h00, q}, {8'h00, REGS[k][15:8]});
    end
    for (int k = 0; k < 14; k++) begin
      a = k % 7;
      d = 8'($random(seed));
      if (a == 0)
        d = (d & 8'hc7) | (8'h08 << (k % 3));
      if (a == 1)
        d[7] = 1'b0;
      xfer(1'b1, REGS[a][23:16], d, q);
      check({8'h00, q}, {8'h00, d & REGS[a][7:0]});
    end
    wr(ADDR_PRIO_LO, 8'h00);
    wr(ADDR_PRIO_HI, 8'h00);
    for (int k = 0; k < 18; k++) begin
      c = CASES[k];
      wr(ADDR_IEN_PRI, 8'h00);
      wr(ADDR_FLAGS, 8'h00);
      wr(ADDR_IEN_SEC, c[39:32]);
      wr(ADDR_PIN_SRC, c[31:24]);
      wr(ADDR_IEN_PRI, c[47:40]);
      n = taken_cnt;
      delay <= 2'($random(seed));
      pin_edge_mode <= 1'($random(seed));
      pof_edge_mode <= 1'($random(seed));
      src <= sources_s'(IDLE ^ (18'h1 << c[55:48]));
      wait_take(n);
      check(taken_vec, c[15:0]);
      check({12'h000, in_service}, 16'h0001);
      xfer(1'b0, ADDR_FLAGS, 8'h00, q);
      check({8'h00, q}, {8'h00, c[23:16]});
      src <= sources_s'(IDLE);
      wr(ADDR_FLAGS, 8'h00);
      ret;
    end
    wake_en <= wake_s'(3'h0);
    wr(ADDR_IEN_SEC, 8'h02);
    wr(ADDR_IEN_PRI, 8'h02);
    n = taken_cnt;
    src <= sources_s'(IDLE ^ 18'h04049);
    repeat (12) @(posedge clk);
    check({8'h00, taken_cnt}, {8'h00, n});
    xfer(1'b0, ADDR_FLAGS, 8'h00, q);
    check({8'h00, q}, 16'h0000);
    wr(ADDR_IEN_PRI, 8'h82);
    wait_take(n);
    check(taken_vec, 16'h000b);
    wake_en <= wake_s'(3'h7);
    src <= sources_s'(IDLE);
    ret;
    for (int k = 0; k < 8; k++) begin
      lo = (k == 0) ? 8'h00 : 8'($random(seed));
      hi = (k == 0) ? 8'h00 : 8'($random(seed));
      wr(ADDR_PRIO_LO, lo);
      wr(ADDR_PRIO_HI, hi);
      wr(ADDR_IEN_PRI, 8'h8a);
      n = taken_cnt;
      src <= sources_s'(IDLE ^ 18'h05000);
      wait_take(n);
      check(taken_vec, win(lo, hi));
      src <= sources_s'(IDLE);
      wr(ADDR_IEN_PRI, 8'h00);
      ret;
    end
    wr(ADDR_PRIO_LO, 8'h0a);
    wr(ADDR_PRIO_HI, 8'h08);
    wr(ADDR_IEN_PRI, 8'h8a);
    n = taken_cnt;
    src <= sources_s'(IDLE ^ 18'h04000);
    wait_take(n);
    src <= sources_s'(IDLE ^ 18'h05000);
    wait_take(n + 8'h01);
    check(taken_vec, 16'h001b);
    check({12'h000, in_service}, 16'h000a);
    ret;
    check({12'h000, in_service}, 16'h0002);
    src <= sources_s'(IDLE);
    ret;
    check({12'h000, in_service}, 16'h0000);
    close_out;
  end
endmodule
